// ==== pkg/nffs_cfg.svh ====
// Constants for the NAND feature set/get host controller
`ifndef NFFS_CFG_SVH
`define NFFS_CFG_SVH
`define NFFS_CMD_SET_FEAT 8'hef
`define NFFS_CMD_GET_FEAT 8'hee
`define NFFS_CMD_STATUS 8'h70
`define NFFS_CMD_READ_MODE 8'h00
`define NFFS_CMD_RESET 8'hff
`define NFFS_FA_TIMING 8'h01
`define NFFS_FA_DRIVE 8'h80
`define NFFS_FA_PULLDOWN 8'h81
`define NFFS_FA_ARRAY 8'h90
`define NFFS_SR_RDY 6
`define NFFS_PARAM_BYTES 4
`define NFFS_CLK_NS 5
`define NFFS_ADL_NS 70
`define NFFS_ADL_CYC ((`NFFS_ADL_NS + `NFFS_CLK_NS - 1) / `NFFS_CLK_NS)
`define NFFS_STROBE_NS 25
`define NFFS_STROBE_CYC ((`NFFS_STROBE_NS + `NFFS_CLK_NS - 1) / `NFFS_CLK_NS)
`define NFFS_WB_NS 100
`define NFFS_WB_CYC ((`NFFS_WB_NS + `NFFS_CLK_NS - 1) / `NFFS_CLK_NS)
`endif

// ==== pkg/nffs_cyc_if.sv ====
// Bus-cycle request and answer between sequencer and pin driver
`timescale 1ns/100ps
interface nffs_cyc_if;
    import nffs_pkg::*;
    logic req;
    nffs_cyc_t kind;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport seq (output req, output kind, output wdata, input done, input rdata);
    modport drv (input req, input kind, input wdata, output done, output rdata);
endinterface

// ==== pkg/nffs_pkg.sv ====
// Types for the NAND feature set/get host controller
package nffs_pkg;
    typedef enum logic [1:0] {
        NFFS_CYC_CMD,
        NFFS_CYC_ADDR,
        NFFS_CYC_WDATA,
        NFFS_CYC_RDATA
    } nffs_cyc_t;
    typedef enum {
        NFFS_IDLE,
        NFFS_CMD,
        NFFS_ADDR,
        NFFS_ADL,
        NFFS_WDATA,
        NFFS_WBUSY,
        NFFS_POLL,
        NFFS_POLLRD,
        NFFS_RDMODE,
        NFFS_RDATA,
        NFFS_DONE
    } nffs_state_t;
endpackage

// ==== rtl/nffs_host.sv ====
// Host controller issuing set-features and get-features to a NAND target
`timescale 1ns/100ps
`include "nffs_cfg.svh"
module nffs_host
    import nffs_pkg::*;
#(
    parameter int ADL_CYC = `NFFS_ADL_CYC,
    parameter int WB_CYC = `NFFS_WB_CYC,
    parameter int STROBE_CYC = `NFFS_STROBE_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // User orders
    input wire logic startReq,
    input wire logic writeNotRead,
    input wire logic [7:0] featAddr,
    input wire logic [31:0] featWrData,
    input wire logic dieIdle,
    output logic startReady,
    output logic doneStrobe,
    output logic [31:0] featRdData,
    output logic refused,
    // NAND pins
    output logic chipEnable_n,
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobe_n,
    output logic read_strobe_n,
    output logic [7:0] ioOut,
    output logic ioOe_n,
    input wire logic [7:0] ioIn,
    input wire logic readyBusy_n
);
    initial begin
        if (ADL_CYC < 1 || ADL_CYC > 255 || WB_CYC < 1 || WB_CYC > 255) $error("delay out of range");
    end
    function automatic logic [7:0] sanitize(input logic [7:0] fa, input logic [7:0] p1);
        unique case (fa)
            `NFFS_FA_TIMING: sanitize = {5'h00, p1[2:0] > 3'h5 ? 3'h0 : p1[2:0]};
            `NFFS_FA_DRIVE, `NFFS_FA_PULLDOWN: sanitize = {6'h00, p1[1:0]};
            `NFFS_FA_ARRAY: sanitize = {4'h0, p1[3], 1'b0, p1[1:0] == 2'h2 ? 2'h0 : p1[1:0]};
            default: sanitize = 8'h00;
        endcase
    endfunction
    function automatic logic defined_addr(input logic [7:0] fa);
        defined_addr = fa == `NFFS_FA_TIMING || fa == `NFFS_FA_DRIVE ||
            fa == `NFFS_FA_PULLDOWN || fa == `NFFS_FA_ARRAY;
    endfunction
    typedef struct packed {
        nffs_state_t state;
        logic wr;
        logic [7:0] fa;
        logic [31:0] wd;
        logic [31:0] rd;
        logic [1:0] idx;
        logic [7:0] cnt;
        logic req;
        nffs_cyc_t kind;
        logic [7:0] wdata;
        logic done;
        logic refused;
        logic ce;
    } nffs_host_t;
    nffs_host_t st;
    nffs_host_t next_st;
    nffs_cyc_if cyc ();
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.req = 1'b0;
        next_st.done = 1'b0;
        next_st.refused = 1'b0;
        unique case (st.state)
            NFFS_IDLE: begin
                if (startReq) begin
                    if (!dieIdle || !readyBusy_n || !defined_addr(featAddr)) begin
                        next_st.refused = 1'b1;
                    end else begin
                        next_st.wr = writeNotRead;
                        next_st.fa = featAddr;
                        next_st.wd = {24'h000000, sanitize(featAddr, featWrData[7:0])};
                        next_st.ce = 1'b1;
                        next_st.req = 1'b1;
                        next_st.kind = NFFS_CYC_CMD;
                        next_st.wdata = writeNotRead ? `NFFS_CMD_SET_FEAT : `NFFS_CMD_GET_FEAT;
                        next_st.state = NFFS_CMD;
                    end
                end
            end
            NFFS_CMD: begin
                if (cyc.done) begin
                    next_st.req = 1'b1;
                    next_st.kind = NFFS_CYC_ADDR;
                    next_st.wdata = st.fa;
                    next_st.state = NFFS_ADDR;
                end
            end
            NFFS_ADDR: begin
                if (cyc.done) begin
                    next_st.cnt = '0;
                    next_st.idx = '0;
                    next_st.state = st.wr ? NFFS_ADL : NFFS_WBUSY;
                end
            end
            NFFS_ADL: begin
                next_st.cnt = st.cnt + 8'd1;
                if (st.cnt == 8'(ADL_CYC - 1)) begin
                    next_st.req = 1'b1;
                    next_st.kind = NFFS_CYC_WDATA;
                    next_st.wdata = st.wd[7:0];
                    next_st.state = NFFS_WDATA;
                end
            end
            NFFS_WDATA: begin
                if (cyc.done) begin
                    if (st.idx == 2'd3) begin
                        next_st.cnt = '0;
                        next_st.state = NFFS_WBUSY;
                    end else begin
                        next_st.idx = st.idx + 2'd1;
                        next_st.req = 1'b1;
                        next_st.kind = NFFS_CYC_WDATA;
                        next_st.wdata = st.wd[8 * (32'(st.idx) + 1) +: 8];
                    end
                end
            end
            NFFS_WBUSY: begin
                next_st.cnt = st.cnt + 8'd1;
                if (st.cnt == 8'(WB_CYC - 1)) begin
                    next_st.req = 1'b1;
                    next_st.kind = NFFS_CYC_CMD;
                    next_st.wdata = `NFFS_CMD_STATUS;
                    next_st.state = NFFS_POLL;
                end
            end
            NFFS_POLL: begin
                if (cyc.done) begin
                    next_st.req = 1'b1;
                    next_st.kind = NFFS_CYC_RDATA;
                    next_st.state = NFFS_POLLRD;
                end
            end
            NFFS_POLLRD: begin
                if (cyc.done) begin
                    next_st.req = 1'b1;
                    if (!cyc.rdata[`NFFS_SR_RDY]) begin
                        next_st.kind = NFFS_CYC_RDATA;
                    end else if (st.wr) begin
                        next_st.req = 1'b0;
                        next_st.state = NFFS_DONE;
                    end else begin
                        next_st.kind = NFFS_CYC_CMD;
                        next_st.wdata = `NFFS_CMD_READ_MODE;
                        next_st.state = NFFS_RDMODE;
                    end
                end
            end
            NFFS_RDMODE: begin
                if (cyc.done) begin
                    next_st.req = 1'b1;
                    next_st.kind = NFFS_CYC_RDATA;
                    next_st.idx = '0;
                    next_st.state = NFFS_RDATA;
                end
            end
            NFFS_RDATA: begin
                if (cyc.done) begin
                    next_st.rd = {cyc.rdata, st.rd[31:8]};
                    if (st.idx == 2'd3) begin
                        next_st.state = NFFS_DONE;
                    end else begin
                        next_st.idx = st.idx + 2'd1;
                        next_st.req = 1'b1;
                        next_st.kind = NFFS_CYC_RDATA;
                    end
                end
            end
            NFFS_DONE: begin
                next_st.ce = 1'b0;
                next_st.done = 1'b1;
                next_st.state = NFFS_IDLE;
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    assign cyc.req = st.req;
    assign cyc.kind = st.kind;
    assign cyc.wdata = st.wdata;
    nffs_pin_drv #(
        .STROBE_CYC(STROBE_CYC)
    ) nffs_pin_drv_i (
        .clk_sys(clk_sys),
        .reset(reset),
        .cyc(cyc.drv),
        .cmdLatch(cmdLatch),
        .addrLatch(addrLatch),
        .writeStrobe_n(writeStrobe_n),
        .read_strobe_n(read_strobe_n),
        .ioOut(ioOut),
        .ioOe_n(ioOe_n),
        .ioIn(ioIn)
    );
    assign startReady = st.state == NFFS_IDLE;
    assign doneStrobe = st.done;
    assign featRdData = st.rd;
    assign refused = st.refused;
    assign chipEnable_n = ~st.ce;
    ////////////////////////////////////////////////////////////////////////////
    busy_refuse_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_IDLE && startReq && (!dieIdle || !readyBusy_n) |=> refused && st.state == NFFS_IDLE)
        else $error("start taken while die busy");
    adl_wait_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_WDATA && $past(st.state) == NFFS_ADL |-> $past(st.cnt) == 8'(ADL_CYC - 1) && st.idx == 2'd0)
        else $error("data before address-to-data delay");
    reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_WDATA && st.idx != 2'd0 && cyc.req |-> st.wdata == 8'h00)
        else $error("reserved byte not zero");
    set_code_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(st.ce) && st.wr |-> st.wdata == `NFFS_CMD_SET_FEAT) else $error("wrong set code");
    get_code_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(st.ce) && !st.wr |-> st.wdata == `NFFS_CMD_GET_FEAT) else $error("wrong get code");
    one_addr_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_ADDR && cyc.done |=> st.state != NFFS_ADDR) else $error("second address byte");
    readmode_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_RDMODE && cyc.done |=> st.state == NFFS_RDATA) else $error("no read mode before data");
    timing_sane_a: assert property (@(posedge clk_sys) disable iff (reset)
        st.state == NFFS_WDATA && st.fa == `NFFS_FA_TIMING |-> st.wd[7:0] <= 8'h05)
        else $error("bad timing mode");
endmodule

// ==== rtl/nffs_pin_drv.sv ====
// One asynchronous NAND bus cycle on the pins
`timescale 1ns/100ps
`include "nffs_cfg.svh"
module nffs_pin_drv
    import nffs_pkg::*;
#(
    parameter int STROBE_CYC = `NFFS_STROBE_CYC
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Sequencer side
    nffs_cyc_if.drv cyc,
    // Pins
    output logic cmdLatch,
    output logic addrLatch,
    output logic writeStrobe_n,
    output logic read_strobe_n,
    output logic [7:0] ioOut,
    output logic ioOe_n,
    input wire logic [7:0] ioIn
);
    initial begin
        if (STROBE_CYC < 1 || STROBE_CYC > 255) $error("STROBE_CYC out of range");
    end
    typedef struct packed {
        logic busy;
        logic [8:0] cnt;
        nffs_cyc_t kind;
        logic cle;
        logic ale;
        logic we;
        logic re;
        logic oe;
        logic [7:0] dout;
        logic [7:0] din;
        logic done;
    } nffs_drv_t;
    nffs_drv_t st;
    nffs_drv_t next_st;
    localparam logic [8:0] HALF = 9'(STROBE_CYC);
    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (!st.busy) begin
            if (cyc.req) begin
                next_st.busy = 1'b1;
                next_st.cnt = '0;
                next_st.kind = cyc.kind;
                next_st.cle = cyc.kind == NFFS_CYC_CMD;
                next_st.ale = cyc.kind == NFFS_CYC_ADDR;
                next_st.oe = cyc.kind != NFFS_CYC_RDATA;
                next_st.dout = cyc.wdata;
                next_st.we = cyc.kind != NFFS_CYC_RDATA;
                next_st.re = cyc.kind == NFFS_CYC_RDATA;
            end
        end else begin
            next_st.cnt = st.cnt + 9'd1;
            if (st.cnt == HALF - 9'd1) begin
                next_st.we = 1'b0;
                next_st.re = 1'b0;
                if (st.kind == NFFS_CYC_RDATA) begin
                    next_st.din = ioIn;
                end
            end
            if (st.cnt == 9'(2 * STROBE_CYC - 1)) begin
                next_st.busy = 1'b0;
                next_st.cle = 1'b0;
                next_st.ale = 1'b0;
                next_st.oe = 1'b0;
                next_st.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    assign cmdLatch = st.cle;
    assign addrLatch = st.ale;
    assign writeStrobe_n = ~st.we;
    assign read_strobe_n = ~st.re;
    assign ioOut = st.dout;
    assign ioOe_n = ~st.oe;
    assign cyc.done = st.done;
    assign cyc.rdata = st.din;
    strobe_width_a: assert property (@(posedge clk_sys) disable iff (reset)
        $rose(writeStrobe_n) |-> st.busy && st.cnt == HALF) else $error("write strobe width wrong");
    data_stable_a: assert property (@(posedge clk_sys) disable iff (reset)
        !writeStrobe_n && !$past(writeStrobe_n) |-> $stable(ioOut)) else $error("data moved under strobe");
endmodule

// ==== tb/nffs_dev_model.sv ====
// Behavioural NAND target answering feature, status and read-mode commands
`timescale 1ns/100ps
`include "nffs_cfg.svh"
module nffs_dev_model #(
    parameter int FEAT_NS = 300,
    parameter int ITC_NS = 700
) (
    // Host pins
    input wire logic chipEnable_n,
    input wire logic cmdLatch,
    input wire logic addrLatch,
    input wire logic writeStrobe_n,
    input wire logic read_strobe_n,
    input wire logic [7:0] ioOut,
    input wire logic ioOe_n,
    // Target answers
    output logic [7:0] ioIn,
    output logic readyBusy_n
);
    logic [31:0] featReg [4];
    logic [31:0] shiftWord;
    logic [7:0] lastCmd;
    logic [7:0] featSel;
    logic [7:0] outByte;
    logic statusMode;
    logic busy;
    int byteIdx;
    int busyNs;
    event startBusy;

    function automatic int slot(input logic [7:0] fa);
        case (fa)
            `NFFS_FA_TIMING: slot = 0;
            `NFFS_FA_DRIVE: slot = 1;
            `NFFS_FA_PULLDOWN: slot = 2;
            `NFFS_FA_ARRAY: slot = 3;
            default: slot = -1;
        endcase
    endfunction

    initial begin
        foreach (featReg[i]) featReg[i] = 32'h0;
        shiftWord = 32'h0;
        lastCmd = 8'h0;
        featSel = 8'h0;
        statusMode = 1'b0;
        busy = 1'b0;
        byteIdx = 0;
        busyNs = FEAT_NS;
    end

    always @(startBusy) begin
        busy = 1'b1;
        #(busyNs);
        busy = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge writeStrobe_n) begin
        if (!chipEnable_n && !ioOe_n) begin
            if (cmdLatch) begin
                if (ioOut == `NFFS_CMD_STATUS) statusMode = 1'b1;
                else if (ioOut == `NFFS_CMD_READ_MODE) statusMode = 1'b0;
                else if (!busy) begin
                    lastCmd = ioOut;
                    statusMode = 1'b0;
                    byteIdx = 0;
                end
            end else if (addrLatch) begin
                if (lastCmd == `NFFS_CMD_SET_FEAT || lastCmd == `NFFS_CMD_GET_FEAT) begin
                    featSel = ioOut;
                    byteIdx = 0;
                    if (lastCmd == `NFFS_CMD_GET_FEAT) begin
                        shiftWord = (slot(ioOut) >= 0) ? featReg[slot(ioOut)] : 32'h0;
                        busyNs = FEAT_NS;
                        ->startBusy;
                    end
                end
            end else if (lastCmd == `NFFS_CMD_SET_FEAT && byteIdx < 4) begin
                shiftWord[byteIdx*8 +: 8] = ioOut;
                byteIdx++;
                if (byteIdx == 4) begin
                    busyNs = (featSel == `NFFS_FA_TIMING && featReg[0] != shiftWord) ? ITC_NS : FEAT_NS;
                    if (slot(featSel) >= 0) featReg[slot(featSel)] = shiftWord;
                    ->startBusy;
                end
            end
        end
    end

    always @(posedge read_strobe_n) begin
        if (!chipEnable_n && !statusMode && lastCmd == `NFFS_CMD_GET_FEAT && byteIdx < 4) byteIdx++;
    end

    // Released bus shows the inverse so a late sample never matches by chance
    assign outByte = statusMode ? {1'b1, !busy, !busy, 5'h0} : shiftWord[(byteIdx % 4)*8 +: 8];
    assign ioIn = (!chipEnable_n && !read_strobe_n) ? outByte : ~outByte;
    assign readyBusy_n = !busy;
endmodule

// ==== tb/nffs_host_tb_top.sv ====
// Self-checking bench for the feature set/get host controller
`timescale 1ns/100ps
`include "nffs_cfg.svh"
module nffs_host_tb_top;
    logic clk_sys, reset, startReq, writeNotRead, dieIdle, startReady, doneStrobe, refused;
    logic chipEnable_n, cmdLatch, addrLatch, writeStrobe_n, read_strobe_n, ioOe_n, readyBusy_n;
    logic devReady, busyHold;
    logic [7:0] featAddr, ioOut, ioIn;
    logic [31:0] featWrData, featRdData;
    int failures = 0;
    int checked = 0;
    int cycles = 0;

    nffs_host nffs_host_i (.clk_sys(clk_sys), .reset(reset), .startReq(startReq), .writeNotRead(writeNotRead),
        .featAddr(featAddr), .featWrData(featWrData), .dieIdle(dieIdle), .startReady(startReady),
        .doneStrobe(doneStrobe), .featRdData(featRdData), .refused(refused), .chipEnable_n(chipEnable_n),
        .cmdLatch(cmdLatch), .addrLatch(addrLatch), .writeStrobe_n(writeStrobe_n),
        .read_strobe_n(read_strobe_n), .ioOut(ioOut), .ioOe_n(ioOe_n), .ioIn(ioIn), .readyBusy_n(readyBusy_n));

    nffs_dev_model nffs_dev_model_i (.chipEnable_n(chipEnable_n), .cmdLatch(cmdLatch), .addrLatch(addrLatch),
        .writeStrobe_n(writeStrobe_n), .read_strobe_n(read_strobe_n), .ioOut(ioOut), .ioOe_n(ioOe_n),
        .ioIn(ioIn), .readyBusy_n(devReady));

    // Bench can hold the busy pin low to exercise the busy refusal
    assign readyBusy_n = devReady && !busyHold;

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic run_op(input logic wr, input logic [7:0] fa, input logic [31:0] wd, output logic d, output logic r);
        int n;
        d = 1'b0;
        r = 1'b0;
        n = 0;
        writeNotRead = wr;
        featAddr = fa;
        featWrData = wd;
        check({31'h0, startReady}, 32'h1);
        startReq = 1'b1;
        @(posedge clk_sys);
        #1;
        startReq = 1'b0;
        check({31'h0, startReady}, {31'h0, refused});
        while (!d && !r && n < 3000) begin
            d = (doneStrobe === 1'b1);
            r = (refused === 1'b1);
            if (!d && !r) begin
                @(posedge clk_sys);
                #1;
                n++;
            end
        end
        @(posedge clk_sys);
        #1;
    endtask

    task automatic set_op(input logic [7:0] fa, input logic [31:0] wd);
        logic d, r;
        run_op(1'b1, fa, wd, d, r);
        check({31'h0, d}, 32'h1);
    endtask

    task automatic get_check(input logic [7:0] fa, input logic [31:0] exp);
        logic d, r;
        run_op(1'b0, fa, 32'h0, d, r);
        check({31'h0, d}, 32'h1);
        check(featRdData, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_defaults;
        get_check(`NFFS_FA_TIMING, 32'h0);
        get_check(`NFFS_FA_DRIVE, 32'h0);
        get_check(`NFFS_FA_PULLDOWN, 32'h0);
        get_check(`NFFS_FA_ARRAY, 32'h0);
        $display("test defaults done");
    endtask

    task automatic test_codes;
        logic [7:0] arr [4] = '{8'h00, 8'h01, 8'h03, 8'h08};
        for (int i = 0; i <= 5; i++) begin
            set_op(`NFFS_FA_TIMING, 32'ha5c35a00 | i);
            get_check(`NFFS_FA_TIMING, i);
        end
        for (int i = 0; i < 4; i++) begin
            set_op(`NFFS_FA_DRIVE, 32'h5a5a5a00 | i);
            set_op(`NFFS_FA_PULLDOWN, 32'h3c3c3c00 | (3 - i));
            get_check(`NFFS_FA_DRIVE, i);
            get_check(`NFFS_FA_PULLDOWN, 3 - i);
            set_op(`NFFS_FA_ARRAY, {24'hffffff, arr[i]});
            get_check(`NFFS_FA_ARRAY, {24'h0, arr[i]});
        end
        $display("test codes done");
    endtask

    task automatic test_sanitize;
        set_op(`NFFS_FA_TIMING, 32'h3);
        set_op(`NFFS_FA_TIMING, 32'h7);
        get_check(`NFFS_FA_TIMING, 32'h0);
        set_op(`NFFS_FA_ARRAY, 32'h8);
        set_op(`NFFS_FA_ARRAY, 32'h2);
        get_check(`NFFS_FA_ARRAY, 32'h0);
        $display("test sanitize done");
    endtask

    task automatic test_refuse;
        logic [7:0] bad [5] = '{8'h00, 8'h02, 8'h7f, 8'h82, 8'hff};
        logic d, r;
        set_op(`NFFS_FA_DRIVE, 32'h2);
        foreach (bad[i]) begin
            run_op(1'b1, bad[i], 32'h1, d, r);
            check({30'h0, d, r}, 32'h1);
        end
        dieIdle = 1'b0;
        run_op(1'b1, `NFFS_FA_DRIVE, 32'h3, d, r);
        check({30'h0, d, r}, 32'h1);
        run_op(1'b0, `NFFS_FA_DRIVE, 32'h0, d, r);
        check({30'h0, d, r}, 32'h1);
        dieIdle = 1'b1;
        busyHold = 1'b1;
        run_op(1'b1, `NFFS_FA_DRIVE, 32'h3, d, r);
        check({30'h0, d, r}, 32'h1);
        busyHold = 1'b0;
        get_check(`NFFS_FA_DRIVE, 32'h2);
        $display("test refuse done");
    endtask

    task automatic test_reset_keep;
        set_op(`NFFS_FA_ARRAY, 32'h8);
        reset = 1'b1;
        @(posedge clk_sys);
        #1;
        check({chipEnable_n, ioOe_n, writeStrobe_n, read_strobe_n, cmdLatch, addrLatch}, 32'h3c);
        reset = 1'b0;
        get_check(`NFFS_FA_ARRAY, 32'h8);
        $display("test reset keep done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles >= 60000) begin
            failures++;
            report_and_stop;
        end
    end

    initial begin
        reset = 1'b1;
        startReq = 1'b0;
        writeNotRead = 1'b0;
        featAddr = 8'h0;
        featWrData = 32'h0;
        dieIdle = 1'b1;
        busyHold = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        test_defaults;
        test_codes;
        test_sanitize;
        test_refuse;
        test_reset_keep;
        report_and_stop;
    end
endmodule
